// file: design/dcbr_regs.vh
`ifndef DCBR_REGS_VH
`define DCBR_REGS_VH

// Register byte offsets
`define DCBR_OFS_CTRL 8'h00
`define DCBR_OFS_STATUS 8'h04
`define DCBR_OFS_PRE_ADDR 8'h08
`define DCBR_OFS_PRE_DATA 8'h0C

// Control register fields
`define DCBR_CTRL_SHAPE_LSB 0
`define DCBR_CTRL_SHAPE_MSB 1
`define DCBR_CTRL_FETCH_FALL 2
`define DCBR_CTRL_STORE_FALL 3
`define DCBR_CTRL_RUN 4
`define DCBR_CTRL_WIDTH 5
`define DCBR_CTRL_RESET 5'h00

// Status register fields
`define DCBR_STAT_STORE_LSB 0
`define DCBR_STAT_FETCH_LSB 16

// Shape codes
`define DCBR_SHAPE_256X16 2'h0
`define DCBR_SHAPE_512X8 2'h1
`define DCBR_SHAPE_1024X4 2'h2
`define DCBR_SHAPE_2048X2 2'h3

// Array geometry
`define DCBR_ROWS 256
`define DCBR_ROW_BITS 16

// Bus response codes
`define DCBR_RESP_OKAY 2'h0
`define DCBR_RESP_SLVERR 2'h2

`endif

// file: design/dcbr_pin_sync.v
`timescale 1ns/10ps

// Two-stage synchroniser for a group of pins
module dcbr_pin_sync #(
  parameter WIDTH = 60
) (
  input wire clk, // System clock
  input wire rst, // Asynchronous reset, active high
  input wire [WIDTH-1:0] pinIn, // Raw pin levels
  output reg [WIDTH-1:0] pinSync // Levels after two flip-flops
);

  reg [WIDTH-1:0] pinMeta;

  // First stage feeds only the second stage
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pinMeta <= {WIDTH{1'b0}};
      pinSync <= {WIDTH{1'b0}};
    end
    else
    begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

endmodule

// file: design/dcbr_block_ram.v
`timescale 1ns/10ps
`include "dcbr_regs.vh"

// Notes on behaviour
// - The array holds 4096 bits and always takes one of four fixed shapes.
// - Shapes are 256x16, 512x8, 1024x4 and 2048x2 with 8 to 11 location bits on both ports.
// - In the 16-bit shape the low eight location bits pick one of 256 words per port.
// - In the 16-bit shape a mask bit of 0 writes that bit and 1 keeps it; narrow shapes ignore it.
// - Store data, store location and fetch location are captured in input registers on the edge.
// - Both port clocks act on rising edges unless falling edges are selected.
// - Falling-edge choice is separate for the store clock and the fetch clock.
// - A word is stored only on an active store edge with store gate and store strobe high.
// - Fetched data changes only on an active fetch edge with fetch gate and fetch strobe high.
// - Contents may be preloaded before user operation starts.
module dcbr_block_ram (
  input wire clk, // System clock, 50 MHz
  input wire rst, // Asynchronous reset, active high
  input wire [7:0] awaddr, // Write address
  input wire awvalid, // Write address valid
  output wire awready, // Write address ready
  input wire [31:0] wdata, // Write data
  input wire [3:0] wstrb, // Write byte strobes
  input wire wvalid, // Write data valid
  output wire wready, // Write data ready
  output reg [1:0] bresp, // Write response
  output reg bvalid, // Write response valid
  input wire bready, // Write response ready
  input wire [7:0] araddr, // Read address
  input wire arvalid, // Read address valid
  output wire arready, // Read address ready
  output reg [31:0] rdata, // Read data
  output reg [1:0] rresp, // Read response
  output reg rvalid, // Read data valid
  input wire rready, // Read data ready
  input wire storeClock, // Store port clock pin
  input wire storeClockGate, // Store port clock enable
  input wire storeStrobe, // Store port write enable
  input wire [10:0] storeLocationBus, // Store location
  input wire [15:0] storeData, // Store data
  input wire [15:0] storeMask, // Store bit mask, 16-bit shape
  input wire fetchClock, // Fetch port clock pin
  input wire fetchClockGate, // Fetch port clock enable
  input wire fetchStrobe, // Fetch port read enable
  input wire [10:0] fetchLocationBus, // Fetch location
  output reg [15:0] fetchData // Fetched data
);

  // Bits that select the valid data lanes of a shape
  function [15:0] dcbrWidthMask;
    input [1:0] shape;
  begin
    case (shape)
      `DCBR_SHAPE_256X16: dcbrWidthMask = 16'hFFFF;
      `DCBR_SHAPE_512X8: dcbrWidthMask = 16'h00FF;
      `DCBR_SHAPE_1024X4: dcbrWidthMask = 16'h000F;
      default: dcbrWidthMask = 16'h0003;
    endcase
  end
  endfunction

  // Bit offset of the addressed lane inside a row
  function [3:0] dcbrLaneShift;
    input [1:0] shape;
    input [10:0] loc;
  begin
    case (shape)
      `DCBR_SHAPE_256X16: dcbrLaneShift = 4'h0;
      `DCBR_SHAPE_512X8: dcbrLaneShift = {loc[0], 3'h0};
      `DCBR_SHAPE_1024X4: dcbrLaneShift = {loc[1:0], 2'h0};
      default: dcbrLaneShift = {loc[2:0], 1'h0};
    endcase
  end
  endfunction

  // Physical row of a location
  function [7:0] dcbrRow;
    input [1:0] shape;
    input [10:0] loc;
  begin
    case (shape)
      `DCBR_SHAPE_256X16: dcbrRow = loc[7:0];
      `DCBR_SHAPE_512X8: dcbrRow = loc[8:1];
      `DCBR_SHAPE_1024X4: dcbrRow = loc[9:2];
      default: dcbrRow = loc[10:3];
    endcase
  end
  endfunction

  // Register state
  reg [`DCBR_CTRL_WIDTH-1:0] ctrl;
  reg [7:0] preAddr;
  reg [15:0] storeCount;
  reg [15:0] fetchCount;

  // Array storage, not reset
  reg [`DCBR_ROW_BITS-1:0] mem [0:`DCBR_ROWS-1];

  wire [1:0] shape = ctrl[`DCBR_CTRL_SHAPE_MSB:`DCBR_CTRL_SHAPE_LSB];
  wire fetchFall = ctrl[`DCBR_CTRL_FETCH_FALL];
  wire storeFall = ctrl[`DCBR_CTRL_STORE_FALL];
  wire run = ctrl[`DCBR_CTRL_RUN];

  // Synchronise every user pin
  wire [59:0] rawPins;
  wire [59:0] syncPins;
  assign rawPins = {fetchLocationBus, fetchStrobe, fetchClockGate, fetchClock,
    storeMask, storeData, storeLocationBus, storeStrobe, storeClockGate, storeClock};

  dcbr_pin_sync #(
    .WIDTH(60)
  ) pinSyncInst (
    .clk(clk),
    .rst(rst),
    .pinIn(rawPins),
    .pinSync(syncPins)
  );

  wire sStoreClock = syncPins[0];
  wire sStoreGate = syncPins[1];
  wire sStoreStrobe = syncPins[2];
  wire [10:0] sStoreLoc = syncPins[13:3];
  wire [15:0] sStoreData = syncPins[29:14];
  wire [15:0] sStoreMask = syncPins[45:30];
  wire sFetchClock = syncPins[46];
  wire sFetchGate = syncPins[47];
  wire sFetchStrobe = syncPins[48];
  wire [10:0] sFetchLoc = syncPins[59:49];

  // Edge detection on the synchronised port clocks
  reg storeClockLast;
  reg fetchClockLast;
  wire storeEdge;
  wire fetchEdge;
  assign storeEdge = storeFall ? (storeClockLast & ~sStoreClock) :
    (~storeClockLast & sStoreClock);
  assign fetchEdge = fetchFall ? (fetchClockLast & ~sFetchClock) :
    (~fetchClockLast & sFetchClock);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      storeClockLast <= 1'b0;
      fetchClockLast <= 1'b0;
    end
    else
    begin
      storeClockLast <= sStoreClock;
      fetchClockLast <= sFetchClock;
    end
  end

  // Store input registers
  reg [7:0] storeRow;
  reg [15:0] storeBits;
  reg [15:0] storeBitEn;
  reg storeGo;
  wire [3:0] storeShift = dcbrLaneShift(shape, sStoreLoc);
  wire [15:0] storeLaneEn = dcbrWidthMask(shape) << storeShift;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      storeRow <= 8'h00;
      storeBits <= 16'h0000;
      storeBitEn <= 16'h0000;
      storeGo <= 1'b0;
    end
    else if (run && storeEdge && sStoreGate)
    begin
      storeRow <= dcbrRow(shape, sStoreLoc);
      storeBits <= (sStoreData & dcbrWidthMask(shape)) << storeShift;
      if (shape == `DCBR_SHAPE_256X16)
        storeBitEn <= ~sStoreMask;
      else
        storeBitEn <= storeLaneEn;
      storeGo <= sStoreStrobe;
    end
    else
      storeGo <= 1'b0;
  end

  // Fetch input registers
  reg [7:0] fetchRow;
  reg [3:0] fetchShift;
  reg [1:0] fetchShape;
  reg fetchGo;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fetchRow <= 8'h00;
      fetchShift <= 4'h0;
      fetchShape <= 2'h0;
      fetchGo <= 1'b0;
    end
    else if (run && fetchEdge && sFetchGate && sFetchStrobe)
    begin
      fetchRow <= dcbrRow(shape, sFetchLoc);
      fetchShift <= dcbrLaneShift(shape, sFetchLoc);
      fetchShape <= shape;
      fetchGo <= 1'b1;
    end
    else
      fetchGo <= 1'b0;
  end

  // Fetched data holds between enabled fetches
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      fetchData <= 16'h0000;
    else if (fetchGo)
      fetchData <= (mem[fetchRow] >> fetchShift) & dcbrWidthMask(fetchShape);
  end

  // Event counters shown in status
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      storeCount <= 16'h0000;
      fetchCount <= 16'h0000;
    end
    else
    begin
      if (storeGo)
        storeCount <= storeCount + 16'h0001;
      if (fetchGo)
        fetchCount <= fetchCount + 16'h0001;
    end
  end

  // Bus write channel holding
  reg awHeld;
  reg wHeld;
  reg [7:0] awAddrQ;
  reg [31:0] wDataQ;
  reg [3:0] wStrbQ;
  assign awready = ~awHeld & ~bvalid;
  assign wready = ~wHeld & ~bvalid;
  wire doWrite = awHeld & wHeld & ~bvalid;

  // Preload word merged with byte strobes
  wire [15:0] preOld = mem[preAddr];
  wire [15:0] preMerged = {wStrbQ[1] ? wDataQ[15:8] : preOld[15:8],
    wStrbQ[0] ? wDataQ[7:0] : preOld[7:0]};
  wire preloadWrite = doWrite && (awAddrQ == `DCBR_OFS_PRE_DATA) && ~run;

  // Array writes: preload while stopped, user stores while running
  always @(posedge clk)
  begin
    if (preloadWrite)
      mem[preAddr] <= preMerged;
    else if (storeGo)
      mem[storeRow] <= (mem[storeRow] & ~storeBitEn) | (storeBits & storeBitEn);
  end

  // Write channel handshake and register updates
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `DCBR_RESP_OKAY;
      ctrl <= `DCBR_CTRL_RESET;
      preAddr <= 8'h00;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld <= 1'b1;
        awAddrQ <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `DCBR_RESP_OKAY;
        case (awAddrQ)
          `DCBR_OFS_CTRL:
          begin
            if (wStrbQ[0])
              ctrl <= wDataQ[`DCBR_CTRL_WIDTH-1:0];
          end
          `DCBR_OFS_PRE_ADDR:
          begin
            if (wStrbQ[0])
              preAddr <= wDataQ[7:0];
          end
          `DCBR_OFS_PRE_DATA:
          begin
            if (run)
              bresp <= `DCBR_RESP_SLVERR;
            else
              preAddr <= preAddr + 8'h01;
          end
          default: bresp <= `DCBR_RESP_SLVERR;
        endcase
      end
    end
  end

  // Read data decode
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;
  always @*
  begin
    next_rdata = 32'h00000000;
    next_rresp = `DCBR_RESP_OKAY;
    case (araddr)
      `DCBR_OFS_CTRL: next_rdata = {27'h0000000, ctrl};
      `DCBR_OFS_STATUS: next_rdata = {fetchCount, storeCount};
      `DCBR_OFS_PRE_ADDR: next_rdata = {24'h000000, preAddr};
      `DCBR_OFS_PRE_DATA: next_rdata = {16'h0000, preOld};
      default: next_rresp = `DCBR_RESP_SLVERR;
    endcase
  end

  // Read channel handshake
  assign arready = ~rvalid;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `DCBR_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

endmodule

// file: tb/dcbr_block_ram_assertions.sv
`timescale 1ns/10ps
// Bus handshake and fetch output checks
module dcbr_block_ram_assertions (
  input logic clk, // Clock
  input logic rst, // Reset
  input logic awvalid, // Address valid
  input logic awready, // Address ready
  input logic wvalid, // Data valid
  input logic wready, // Data ready
  input logic [1:0] bresp, // Write response
  input logic bvalid, // Response valid
  input logic bready, // Response ready
  input logic arvalid, // Read address valid
  input logic arready, // Read address ready
  input logic [31:0] rdata, // Read data
  input logic [1:0] rresp, // Read response
  input logic rvalid, // Read valid
  input logic rready, // Read ready
  input logic fetchClockGate, // Fetch gate
  input logic fetchStrobe, // Fetch enable
  input logic [15:0] fetchData // Fetched word
);
  logic [2:0] idleCnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // Cycles with the fetch port disabled, saturating
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      idleCnt <= 3'h0;
    else if (fetchStrobe && fetchClockGate)
      idleCnt <= 3'h0;
    else if (idleCnt != 3'h7)
      idleCnt <= idleCnt + 3'h1;
  end
  a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  a_error_zero: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
    else $error("error read returned data");
  a_fetch_holds: assert property (idleCnt == 3'h7 |=> $stable(fetchData))
    else $error("fetched word changed while disabled");
endmodule
bind dcbr_block_ram dcbr_block_ram_assertions dcbr_block_ram_assertions_i (.clk, .rst,
  .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready, .fetchClockGate, .fetchStrobe, .fetchData);

// file: tb/dcbr_fabric_model.sv
`timescale 1ns/10ps
// User fabric driving the store and fetch ports
module dcbr_fabric_model (
  input logic clk, // Clock
  output logic storeClock, // Store pin clock
  output logic storeClockGate, // Store gate
  output logic storeStrobe, // Store enable
  output logic [10:0] storeLocationBus, // Store location
  output logic [15:0] storeData, // Store data
  output logic [15:0] storeMask, // Store mask
  output logic fetchClock, // Fetch pin clock
  output logic fetchClockGate, // Fetch gate
  output logic fetchStrobe, // Fetch enable
  output logic [10:0] fetchLocationBus // Fetch location
);
  // Pin clocks idle low, ports disabled
  initial
  begin
    storeClock = 1'h0;
    storeClockGate = 1'h0;
    storeStrobe = 1'h0;
    storeLocationBus = 11'h0;
    storeData = 16'h0;
    storeMask = 16'h0;
    fetchClock = 1'h0;
    fetchClockGate = 1'h0;
    fetchStrobe = 1'h0;
    fetchLocationBus = 11'h0;
  end
  // One pin clock pulse; the values change between edges so only the active edge counts
  task automatic storeOp(input logic [10:0] la, input logic [15:0] da, input logic [10:0] lb,
    input logic [15:0] db, input logic [15:0] mk, input logic en, input logic gt);
    begin
      @(posedge clk);
      storeLocationBus <= la;
      storeData <= da;
      storeMask <= mk;
      storeStrobe <= en;
      storeClockGate <= gt;
      repeat (3) @(posedge clk);
      storeClock <= 1'h1;
      repeat (4) @(posedge clk);
      storeLocationBus <= lb;
      storeData <= db;
      repeat (4) @(posedge clk);
      storeClock <= 1'h0;
      repeat (6) @(posedge clk);
      storeStrobe <= 1'h0;
      storeClockGate <= 1'h0;
      storeData <= ~db;
      storeLocationBus <= ~lb;
    end
  endtask
  // Same pulse shape for the fetch port
  task automatic fetchOp(input logic [10:0] la, input logic [10:0] lb, input logic en,
    input logic gt);
    begin
      @(posedge clk);
      fetchLocationBus <= la;
      fetchStrobe <= en;
      fetchClockGate <= gt;
      repeat (3) @(posedge clk);
      fetchClock <= 1'h1;
      repeat (4) @(posedge clk);
      fetchLocationBus <= lb;
      repeat (4) @(posedge clk);
      fetchClock <= 1'h0;
      repeat (6) @(posedge clk);
      fetchStrobe <= 1'h0;
      fetchClockGate <= 1'h0;
      fetchLocationBus <= ~lb;
    end
  endtask
endmodule

// file: tb/dcbr_block_ram_test.sv
`timescale 1ns/10ps
`include "dcbr_regs.vh"
// Self-checking bench for the block RAM
module dcbr_block_ram_test;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  wire awready, wready, bvalid, arready, rvalid, storeClock, storeClockGate, storeStrobe;
  wire fetchClock, fetchClockGate, fetchStrobe;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [10:0] storeLocationBus, fetchLocationBus;
  wire [15:0] storeData, storeMask, fetchData;
  int miscompares = 0, samplesChecked = 0;
  dcbr_block_ram dcbr_block_ram_i (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .storeClock, .storeClockGate, .storeStrobe, .storeLocationBus,
    .storeData, .storeMask, .fetchClock, .fetchClockGate, .fetchStrobe, .fetchLocationBus,
    .fetchData);
  dcbr_fabric_model dcbr_fabric_model_i (.clk, .storeClock, .storeClockGate, .storeStrobe,
    .storeLocationBus, .storeData, .storeMask, .fetchClock, .fetchClockGate, .fetchStrobe,
    .fetchLocationBus);
  // Clock and watchdog
  initial
  begin
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (8000) @(posedge clk);
    miscompares++;
    closeOut();
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
      samplesChecked++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task automatic closeOut();
    begin
      if (miscompares == 0 && samplesChecked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Write with both channels offered together, response taken a cycle late
  task automatic busWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      do
      begin
        @(posedge clk);
        if (awready)
          awvalid <= 1'h0;
        if (wready)
          wvalid <= 1'h0;
      end while (!bvalid);
      check("bresp", {30'h0, bresp}, {30'h0, er});
      bready <= 1'h1;
      @(posedge clk);
      bready <= 1'h0;
    end
  endtask
  task automatic busRead(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      do
      begin
        @(posedge clk);
        if (arready)
          arvalid <= 1'h0;
      end while (!rvalid);
      check("rdata", rdata, ed);
      check("rresp", {30'h0, rresp}, {30'h0, er});
      rready <= 1'h1;
      @(posedge clk);
      rready <= 1'h0;
    end
  endtask
  // Main sequence
  initial
  begin
    logic [1:0] s;
    logic ff, fs;
    logic [10:0] loc;
    logic [15:0] d, w;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    busRead(`DCBR_OFS_CTRL, 32'h0, `DCBR_RESP_OKAY);
    busRead(8'h10, 32'h0, `DCBR_RESP_SLVERR);
    busWrite(`DCBR_OFS_STATUS, 32'h1, `DCBR_RESP_SLVERR);
    busWrite(`DCBR_OFS_PRE_ADDR, 32'h0, `DCBR_RESP_OKAY);
    for (int i = 1; i < 5; i++)
      busWrite(`DCBR_OFS_PRE_DATA, 32'h1111 * i, `DCBR_RESP_OKAY);
    busRead(`DCBR_OFS_PRE_ADDR, 32'h4, `DCBR_RESP_OKAY);
    busWrite(`DCBR_OFS_PRE_ADDR, 32'h1, `DCBR_RESP_OKAY);
    busRead(`DCBR_OFS_PRE_DATA, 32'h2222, `DCBR_RESP_OKAY);
    // Low byte only: the upper byte of the row must survive the merge
    wstrb <= 4'h1;
    busWrite(`DCBR_OFS_PRE_DATA, 32'hAB, `DCBR_RESP_OKAY);
    wstrb <= 4'hF;
    busWrite(`DCBR_OFS_PRE_ADDR, 32'h1, `DCBR_RESP_OKAY);
    busRead(`DCBR_OFS_PRE_DATA, 32'h22AB, `DCBR_RESP_OKAY);
    busWrite(`DCBR_OFS_CTRL, 32'h10, `DCBR_RESP_OKAY);
    busWrite(`DCBR_OFS_PRE_DATA, 32'h0, `DCBR_RESP_SLVERR);
    dcbr_fabric_model_i.fetchOp(11'h0, 11'h0, 1'h1, 1'h1);
    check("fetchData", {16'h0, fetchData}, 32'h1111);
    dcbr_fabric_model_i.storeOp(11'h2, 16'hFFFF, 11'h2, 16'hFFFF, 16'h00FF, 1'h1, 1'h1);
    dcbr_fabric_model_i.storeOp(11'h3, 16'h0, 11'h3, 16'h0, 16'h0, 1'h0, 1'h1);
    dcbr_fabric_model_i.storeOp(11'h3, 16'h0, 11'h3, 16'h0, 16'h0, 1'h1, 1'h0);
    dcbr_fabric_model_i.fetchOp(11'h2, 11'h2, 1'h1, 1'h1);
    check("fetchData", {16'h0, fetchData}, 32'hFF33);
    dcbr_fabric_model_i.fetchOp(11'h3, 11'h3, 1'h1, 1'h1);
    check("fetchData", {16'h0, fetchData}, 32'h4444);
    dcbr_fabric_model_i.fetchOp(11'h2, 11'h2, 1'h0, 1'h1);
    dcbr_fabric_model_i.fetchOp(11'h2, 11'h2, 1'h1, 1'h0);
    check("fetchData", {16'h0, fetchData}, 32'h4444);
    // Every shape with every edge choice, at the top locations
    for (int k = 0; k < 16; k++)
    begin
      s = k[1:0];
      ff = k[2];
      fs = k[3];
      loc = 11'((1 << (8 + s)) - 1 - k / 4);
      d = 16'hA5C3 + 16'(k * 16'h1111);
      w = 16'((32'h1 << (16 >> s)) - 32'h1);
      busWrite(`DCBR_OFS_CTRL, {27'h0, 1'h0, fs, ff, s}, `DCBR_RESP_OKAY);
      busWrite(`DCBR_OFS_CTRL, {27'h0, 1'h1, fs, ff, s}, `DCBR_RESP_OKAY);
      dcbr_fabric_model_i.storeOp(loc, d, loc, ~d, (s == 2'h0) ? 16'h0 : 16'hFFFF, 1'h1, 1'h1);
      dcbr_fabric_model_i.fetchOp(ff ? loc ^ 11'h1 : loc, ff ? loc : loc ^ 11'h1, 1'h1, 1'h1);
      check("fetchData", {16'h0, fetchData}, {16'h0, (fs ? ~d : d) & w});
    end
    busRead(`DCBR_OFS_STATUS, 32'h00130011, `DCBR_RESP_OKAY);
    // Two byte fetches joined by outside logic into one wider word
    busWrite(`DCBR_OFS_CTRL, 32'h11, `DCBR_RESP_OKAY);
    dcbr_fabric_model_i.fetchOp(11'h4, 11'h4, 1'h1, 1'h1);
    d = fetchData;
    dcbr_fabric_model_i.fetchOp(11'h5, 11'h5, 1'h1, 1'h1);
    check("wideWord", {16'h0, fetchData[7:0], d[7:0]}, 32'h0000FF33);
    closeOut();
  end
endmodule
